/* File: rtl/xq_core.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Exchange and quotient register core with sequence control
module xq_core (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Timing from command timing and distributor
  input wire logic ccp,
  input wire logic main_pulse_zero,
  input wire logic [10:0] seq_start,
  input wire logic [43:0] seq_len,
  output logic mpd_halt,
  output logic sequence_done_pulse,
  output logic [10:0] seq_busy,
  output logic [10:0] seq_step,
  // Exchange register commands
  input wire logic clear_x,
  input wire logic complement_x,
  input wire logic load_x,
  input wire logic [2:0] load_src,
  input wire logic q_zero_to_x,
  // Exchange register sources
  input wire logic [35:0] drum_store_in,
  input wire logic [35:0] core_store_in,
  input wire logic [35:0] io_reg_one_in,
  input wire logic [35:0] io_reg_two_in,
  input wire logic [14:0] storage_address_reg_in,
  // Quotient commands
  input wire logic clear_q,
  input wire logic x_to_q,
  input wire logic shift_q,
  input wire logic tape_to_q,
  input wire logic set_q0,
  input wire logic [1:0] tape_output_reg,
  input wire logic q_to_tape,
  // Accumulator unit operations
  input wire logic clear_a,
  input wire logic add_x_to_a,
  input wire logic shift_a,
  input wire logic decr_a,
  // Storage access to quotient
  input wire logic [14:0] store_addr,
  input wire logic store_wr,
  input wire logic store_rd,
  output logic q_selected,
  // Results
  output logic [35:0] x,
  output logic x_top,
  output logic x_top_n,
  output logic [35:0] q,
  output logic q0,
  output logic q1,
  output logic q35,
  output logic [71:0] acc,
  output logic [1:0] tape_input_reg
);
  // ==========================================================
  // Sequence control
  logic [10:0] done_v;
  logic start_any;
  logic done_any;
  logic halt_r;
  logic halt_nxt;

  // Eleven generators, each with its own start line and step count
  for (genvar i = 0; i < xq_pkg::NUM_SEQ; i++) begin : g_seq
    xq_seq_gen u_gen (
      .clock(clock),
      .rst(rst),
      .start(seq_start[i]),
      .ccp(ccp),
      .seq_len(seq_len[4*i +: 4]),
      .busy(seq_busy[i]),
      .step(seq_step[i]),
      .done(done_v[i])
    );
  end

  // Only one sequence runs at a time, so any done ends the halt
  assign start_any = |seq_start;
  assign done_any = |done_v;

  // Halt from start until the resume; a new start in the resume cycle wins
  always_comb begin
    halt_nxt = halt_r;
    if (start_any) begin
      halt_nxt = 1'b1;
    end else if (done_any) begin
      halt_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halt_r <= 1'b0;
    end else begin
      halt_r <= halt_nxt;
    end
  end

  // The start halts at once, so the distributor never slips a pulse
  assign mpd_halt = halt_r || start_any;
  assign sequence_done_pulse = done_any;

  // ==========================================================
  // Storage decode: only the top octal digit counts
  function automatic logic hits_q(input logic [14:0] a);
    hits_q = a[14:xq_pkg::TOP_DIGIT_LSB] == xq_pkg::QREG_DIGIT;
  endfunction

  logic store_hit;
  logic wr_q;
  logic rd_q;

  // Addresses outside the top digit belong to other stores
  assign store_hit = hits_q(store_addr);
  assign q_selected = store_hit;
  assign wr_q = store_wr && store_hit;
  assign rd_q = store_rd && store_hit;

  // ==========================================================
  // Quotient register
  logic [35:0] q_w;
  logic [35:0] x_r;
  logic q_clear_cmd;
  logic q_load_cmd;

  // A storage write is the same clear-then-load pair as an explicit one
  assign q_clear_cmd = clear_q || wr_q;
  assign q_load_cmd = x_to_q || wr_q;

  xq_qreg u_q (
    .clock(clock),
    .rst(rst),
    .ccp(ccp),
    .clear_q(q_clear_cmd),
    .x_to_q(q_load_cmd),
    .shift_q(shift_q),
    .tape_to_q(tape_to_q),
    .set_q0(set_q0),
    .x_in(x_r),
    .tape_out_bits(tape_output_reg),
    .q(q_w)
  );

  assign q = q_w;
  assign q0 = q_w[0];
  assign q1 = q_w[1];
  assign q35 = q_w[35];

  // ==========================================================
  // Exchange register
  logic [35:0] acc_right;
  logic [35:0] src_word;
  logic [35:0] x_cleared;
  logic [35:0] x_base;
  logic [35:0] x_nxt;
  logic [71:0] acc_r;
  logic [71:0] acc_nxt;
  logic x_zero_xfer;
  logic x_one_xfer;

  // Only the right half of the accumulator loads into the exchange register
  assign acc_right = acc_r[35:0];

  // Unused source codes load nothing, so a stray code only clears
  function automatic logic [35:0] pick(input logic [2:0] s,
      input logic [35:0] d, input logic [35:0] c, input logic [35:0] a,
      input logic [35:0] i1, input logic [35:0] i2, input logic [14:0] sa);
    unique case (s)
      xq_pkg::XQ_SRC_DRUM: pick = d;
      xq_pkg::XQ_SRC_CORE: pick = c;
      xq_pkg::XQ_SRC_ACC: pick = a;
      xq_pkg::XQ_SRC_IO1: pick = i1;
      xq_pkg::XQ_SRC_IO2: pick = i2;
      xq_pkg::XQ_SRC_SAR: pick = {21'h0, sa};
      default: pick = xq_pkg::WORD_ZERO;
    endcase
  endfunction

  assign src_word = pick(load_src, drum_store_in, core_store_in, acc_right,
    io_reg_one_in, io_reg_two_in, storage_address_reg_in);

  // Zero transfer from Q outranks a one transfer; both need a pulse
  assign x_zero_xfer = ccp && (q_zero_to_x || rd_q);
  assign x_one_xfer = ccp && load_x && !x_zero_xfer;

  // Main pulse zero acts as a clear whenever it meets a pulse
  assign x_cleared = (clear_x || main_pulse_zero) ? xq_pkg::WORD_ZERO : x_r;

  // Clear, then complement, then transfer, all folded into one edge
  always_comb begin
    x_base = x_cleared;
    if (complement_x) begin
      x_base = ~x_cleared;
    end
  end

  // Stage actions in the order the flip-flops would see them
  always_comb begin
    x_nxt = x_r;
    if (ccp) begin
      x_nxt = x_base;
    end else if (main_pulse_zero) begin
      // Without a pulse only main pulse zero may touch the stages
      x_nxt = xq_pkg::WORD_ZERO;
    end
    if (ccp && rd_q) begin
      // Clear with complement gives all ones, then zeros of Q clear it
      x_nxt = xq_pkg::WORD_ONES;
    end
    if (x_zero_xfer) begin
      x_nxt = x_nxt & q_w;
    end
    if (x_one_xfer) begin
      x_nxt = x_nxt | src_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      x_r <= xq_pkg::WORD_ZERO;
    end else begin
      x_r <= x_nxt;
    end
  end

  assign x = x_r;
  assign x_top = x_r[35];
  assign x_top_n = ~x_r[35];

  // ==========================================================
  // Accumulator unit operations
  logic [71:0] x_wide;
  logic [71:0] acc_sum;
  logic [71:0] acc_dec;
  logic [71:0] acc_rot;

  // Sign-extend the ones-complement word to the wide modulus before adding
  assign x_wide = {{36{x_r[35]}}, x_r};
  assign acc_sum = xq_pkg::xq_add_ea(acc_r, x_wide);
  // Adding minus one with end-around carry lowers by exactly one
  assign acc_dec = xq_pkg::xq_add_ea(acc_r, ~xq_pkg::ACC_ONE);
  // Shift is circular; the top bit wraps to the bottom
  assign acc_rot = {acc_r[70:0], acc_r[71]};

  // One unit operation per pulse; the order settles clashing commands
  always_comb begin
    acc_nxt = acc_r;
    if (ccp) begin
      if (clear_a) begin
        acc_nxt = xq_pkg::ACC_ZERO;
      end else if (add_x_to_a) begin
        acc_nxt = acc_sum;
      end else if (shift_a) begin
        acc_nxt = acc_rot;
      end else if (decr_a) begin
        acc_nxt = acc_dec;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_r <= xq_pkg::ACC_ZERO;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  assign acc = acc_r;

  // ==========================================================
  // Tape input register fed from the low quotient pair
  logic [1:0] tir_r;
  logic [1:0] tir_nxt;

  // Holds its pair until the next copy, while the line is written
  always_comb begin
    tir_nxt = tir_r;
    if (ccp && q_to_tape) begin
      tir_nxt = q_w[1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tir_r <= xq_pkg::PAIR_ZERO;
    end else begin
      tir_r <= tir_nxt;
    end
  end

  assign tape_input_reg = tir_r;
endmodule
`default_nettype wire

/* File: rtl/xq_pkg.sv */
// ==========================================================
// How it works
// - Any sequence start also halts the main pulse distributor until done.
// - A finishing sequence generator issues a one-cycle resume pulse.
// - Eleven sequence generators, each started alone, stepping on clock pulses.
// - Addition unit op adds the exchange register into the accumulator.
// - Shift unit op rotates accumulator, quotient or both one place left.
// - Decrement unit op lowers the accumulator by exactly one.
// - Exchange register is 36 stages and alone can be complemented.
// - Complement command inverts every exchange stage whatever it held.
// - Ones-complement notation makes complementing an arithmetic negation.
// - Ordinary exchange loads clear first, then set stages where source is one.
// - Load from quotient: clear, complement to ones, clear where quotient is zero.
// - Zero-transfer from quotient leaves bitwise AND in the exchange register.
// - Exchange register clears on main pulse zero of every instruction.
// - True and inverted top exchange stage go to sequence control.
// - Exchange talks both ways with stores, accumulator, quotient, I/O registers.
// - Exchange holds the operand for arithmetic and logical operations.
// - Quotient is 36 stages, rotating left, top stage wrapping to bottom.
// - Quotient answers as one storage word when first octal digit is 1.
// - Quotient assembles and disassembles tape words two bits at a time.
// - Storage write into quotient clears it then copies exchange ones.
// - Tape write copies two low quotient bits into the tape input register.
// ==========================================================
package xq_pkg;
  localparam int WORD_W = 36;
  localparam int ACC_W = 72;
  localparam int NUM_SEQ = 11;
  localparam int ADDR_W = 15;
  localparam int TOP_DIGIT_LSB = 12;
  localparam logic [2:0] QREG_DIGIT = 3'h1;
  localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0_0000_0000;
  localparam logic [WORD_W-1:0] WORD_ONES = 36'hf_ffff_ffff;
  localparam logic [ACC_W-1:0] ACC_ZERO = 72'h0;
  localparam logic [ACC_W-1:0] ACC_ONE = 72'h1;
  localparam logic [1:0] PAIR_ZERO = 2'h0;
  localparam logic [3:0] STEP_ZERO = 4'h0;
  // Default step count of a generator; each one takes its own count from seq_len
  localparam logic [3:0] SEQ_LEN_DEFAULT = 4'h3;

  // Exchange source select for clear-then-set loads
  typedef enum logic [2:0] {
    XQ_SRC_DRUM = 3'b000,
    XQ_SRC_CORE = 3'b001,
    XQ_SRC_ACC = 3'b010,
    XQ_SRC_IO1 = 3'b011,
    XQ_SRC_IO2 = 3'b100,
    XQ_SRC_SAR = 3'b101
  } xq_src_e;

  // Two's-to-ones: end-around carry add of a word into a wider value
  function automatic logic [ACC_W-1:0] xq_add_ea(input logic [ACC_W-1:0] a,
      input logic [ACC_W-1:0] b);
    logic [ACC_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    xq_add_ea = s[ACC_W-1:0] + {{(ACC_W-1){1'b0}}, s[ACC_W]};
  endfunction

  // Left circular rotate by one place
  function automatic logic [WORD_W-1:0] xq_rot(input logic [WORD_W-1:0] v);
    xq_rot = {v[WORD_W-2:0], v[WORD_W-1]};
  endfunction
endpackage

/* File: rtl/xq_qreg.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Quotient register, rotating left
module xq_qreg (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Commands, one clock pulse each
  input wire logic ccp,
  input wire logic clear_q,
  input wire logic x_to_q,
  input wire logic shift_q,
  input wire logic tape_to_q,
  input wire logic set_q0,
  // Data
  input wire logic [35:0] x_in,
  input wire logic [1:0] tape_out_bits,
  output logic [35:0] q
);
  logic [35:0] q_r;

  // Clear wins first, then ones are ORed in, so a clear-and-load lands in one edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= xq_pkg::WORD_ZERO;
    end else if (ccp) begin
      if (shift_q) begin
        q_r <= xq_pkg::xq_rot(q_r);
      end else begin
        q_r <= (clear_q ? xq_pkg::WORD_ZERO : q_r)
          | (x_to_q ? x_in : xq_pkg::WORD_ZERO)
          | {34'h0, tape_to_q ? tape_out_bits : xq_pkg::PAIR_ZERO}
          | {35'h0, set_q0};
      end
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

/* File: rtl/xq_seq_gen.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Single sequence generator
module xq_seq_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic ccp,
  input wire logic [3:0] seq_len,
  // Status
  output logic busy,
  output logic step,
  output logic done
);
  logic [3:0] cnt_r;
  logic busy_r;

  // Steps only on controlled clock pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r <= xq_pkg::STEP_ZERO;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= xq_pkg::STEP_ZERO;
    end else if (busy_r && ccp) begin
      if (cnt_r + 4'h1 >= seq_len) begin
        busy_r <= 1'b0;
      end
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign busy = busy_r;
  assign step = busy_r && ccp;
  assign done = busy_r && ccp && (cnt_r + 4'h1 >= seq_len);
endmodule
`default_nettype wire

/* File: testbench/exchange_quotient_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench
module exchange_quotient_regs_bench;
  localparam logic [16:0] CLX = 17'h1, CMX = 17'h2, LDX = 17'h4;
  localparam logic [16:0] QZX = 17'h8, CLQ = 17'h10, XQ = 17'h20;
  localparam logic [16:0] SHQ = 17'h40, TQ = 17'h80, S0 = 17'h100;
  localparam logic [16:0] QT = 17'h200, CLA = 17'h400, ADA = 17'h800;
  localparam logic [16:0] SHA = 17'h1000, DCA = 17'h2000, SW = 17'h4000;
  localparam logic [16:0] SR = 17'h8000, MP0 = 17'h10000;
  logic clock = 1'b0, rst = 1'b1, ccp = 1'b1, go = 1'b0;
  logic [16:0] c = 17'h0;
  logic [2:0] src = 3'h0;
  logic [3:0] idx = 4'h0;
  logic [43:0] len = 44'h0;
  logic [35:0] dr = 36'h0, co = 36'h0, i1 = 36'h0, i2 = 36'h0;
  logic [14:0] sa = 15'h0, ad = 15'h0;
  logic [1:0] tb = 2'h0, tir;
  logic [10:0] st;
  logic [4:0] hc;
  logic halt, done, xt, xtn, qsel;
  logic [35:0] x, q, e, qm;
  logic [71:0] acc, ea = 72'h0;
  integer seed = 94;
  int failures = 0, compares = 0;

  xq_core u_dut (.clock, .rst, .ccp, .main_pulse_zero(c[16]),
    .seq_start(st), .seq_len(len), .mpd_halt(halt),
    .sequence_done_pulse(done), .seq_busy(), .seq_step(),
    .clear_x(c[0]), .complement_x(c[1]), .load_x(c[2]), .load_src(src),
    .q_zero_to_x(c[3]), .drum_store_in(dr), .core_store_in(co),
    .io_reg_one_in(i1), .io_reg_two_in(i2), .storage_address_reg_in(sa),
    .clear_q(c[4]), .x_to_q(c[5]), .shift_q(c[6]), .tape_to_q(c[7]),
    .set_q0(c[8]), .tape_output_reg(tb), .q_to_tape(c[9]),
    .clear_a(c[10]), .add_x_to_a(c[11]), .shift_a(c[12]),
    .decr_a(c[13]), .store_addr(ad), .store_wr(c[14]), .store_rd(c[15]),
    .q_selected(qsel), .x, .x_top(xt), .x_top_n(xtn), .q, .q0(), .q1(),
    .q35(), .acc, .tape_input_reg(tir));
  xq_ctl_model u_ctl (.clock, .rst, .go, .idx, .mpd_halt(halt),
    .seq_start(st), .hc);

  function automatic logic [3:0] nib(input int g);
    nib = (g == 10) ? 4'h1 : 4'(15 - g);
  endfunction
  function automatic logic [35:0] srcv(input int s);
    case (s)
      0: srcv = dr;
      1: srcv = co;
      2: srcv = ea[35:0];
      3: srcv = i1;
      4: srcv = i2;
      default: srcv = {21'h0, sa};
    endcase
  endfunction
  // End-around carry keeps ones-complement sums right
  function automatic logic [71:0] eadd(input logic [71:0] a, b);
    logic [72:0] s;
    s = {1'b0, a} + {1'b0, b};
    eadd = s[71:0] + {71'h0, s[72]};
  endfunction
  task chk(input string n, input logic [71:0] ex, got);
    compares++;
    if (ex !== got) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, ex, got);
    end
  endtask
  // Fresh data lands on the rising edge that takes the op, ready for the next op
  task op(input logic [16:0] v, input int s = 0, input int hi = 0);
    @(posedge clock) begin
      c <= v;
      src <= 3'(s);
      ad <= {3'(hi), 12'($random(seed))};
    end
    @(posedge clock) begin
      c <= 17'h0;
      dr <= 36'({$random(seed), $random(seed)});
      co <= 36'({$random(seed), $random(seed)});
      i1 <= 36'({$random(seed), $random(seed)});
      i2 <= 36'({$random(seed), $random(seed)});
      sa <= 15'($random(seed));
      tb <= 2'($random(seed));
    end
    #1;
  endtask
  task end_of_test();
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial forever #2.5 clock = ~clock;
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
  initial begin
    for (int g = 0; g < 11; g++) len[g*4+:4] = nib(g);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int g = 0; g < 11; g++) begin
      @(posedge clock) begin
        idx <= 4'(g);
        go <= 1'b1;
      end
      @(posedge clock) go <= 1'b0;
      repeat (20) @(posedge clock);
      #1 chk("halt cycles", 72'(nib(g)) + 72'h1, 72'(hc));
    end
    $display("End of sequence test");
    for (int s = 0; s < 6; s++) begin
      e = srcv(s);
      op(CLX | LDX, s);
      chk("x load", e, x);
    end
    e = ~x;
    op(CMX);
    chk("x complement", e, x);
    chk("x top", {e[35], ~e[35]}, {xt, xtn});
    @(posedge clock) ccp <= 1'b0;
    op(CMX);
    chk("x no pulse", e, x);
    op(MP0);
    chk("x pulse zero", 36'h0, x);
    @(posedge clock) ccp <= 1'b1;
    $display("End of exchange test");
    qm = dr;
    op(CLX | LDX, 0);
    op(SW, 0, 1);
    chk("q write", qm, q);
    chk("q select", 72'h1, 72'(qsel));
    op(CLX | LDX, 1);
    op(SW, 0, 2);
    chk("q miss", qm, q);
    op(SR, 0, 1);
    chk("x from q", qm, x);
    e = co;
    op(CLX | LDX, 1);
    op(QZX);
    chk("x and q", e & qm, x);
    op(SHQ);
    op(SHQ);
    chk("q rotate", {qm[33:0], qm[35:34]}, q);
    e = {34'h0, tb};
    op(CLQ | TQ);
    chk("q tape", e, q);
    op(QT);
    chk("tape in", e, 72'(tir));
    op(CLQ | S0);
    chk("q set0", 36'h1, q);
    $display("End of quotient test");
    e = dr;
    op(CLX | LDX, 0);
    op(CLA);
    op(ADA);
    ea = {{36{e[35]}}, e};
    chk("acc add", ea, acc);
    op(DCA);
    ea = eadd(ea, ~72'h1);
    chk("acc decrement", ea, acc);
    op(SHA);
    chk("acc shift", {ea[70:0], ea[71]}, acc);
    $display("End of accumulator test");
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: testbench/xq_core_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Core checker
module xq_core_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Commands
  input wire logic ccp,
  input wire logic main_pulse_zero,
  input wire logic clear_x,
  input wire logic complement_x,
  input wire logic load_x,
  input wire logic q_zero_to_x,
  input wire logic store_rd,
  input wire logic shift_q,
  input wire logic [10:0] seq_start,
  input wire logic [14:0] store_addr,
  // Results
  input wire logic mpd_halt,
  input wire logic sequence_done_pulse,
  input wire logic q_selected,
  input wire logic x_top,
  input wire logic x_top_n,
  input wire logic q0,
  input wire logic q1,
  input wire logic q35,
  input wire logic [10:0] seq_busy,
  input wire logic [10:0] seq_step,
  input wire logic [35:0] x,
  input wire logic [35:0] q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_start; |seq_start; endsequence
  sequence s_xalone;
    !(clear_x | load_x | store_rd | main_pulse_zero);
  endsequence
  property p_halt; s_start |-> mpd_halt; endproperty
  a_halt: assert property (p_halt) else $error("no halt at start");
  property p_done; sequence_done_pulse |-> mpd_halt; endproperty
  a_done: assert property (p_done) else $error("done while run");
  property p_comp;
    (ccp && complement_x && !q_zero_to_x) and s_xalone |=> x == ~$past(x);
  endproperty
  a_comp: assert property (p_comp) else $error("bad complement");
  property p_and;
    (ccp && q_zero_to_x && !complement_x) and s_xalone
      |=> x == ($past(x) & $past(q));
  endproperty
  a_and: assert property (p_and) else $error("bad and");
  property p_mp0; main_pulse_zero && !ccp |=> x == 36'h0; endproperty
  a_mp0: assert property (p_mp0) else $error("x not cleared");
  property p_top; x_top == x[35] && x_top_n == !x[35]; endproperty
  a_top: assert property (p_top) else $error("bad top stage");
  property p_qrot;
    ccp && shift_q |=> q == {$past(q[34:0]), $past(q[35])};
  endproperty
  a_qrot: assert property (p_qrot) else $error("bad q rotate");
  property p_qsel; q_selected == (store_addr[14:12] == 3'h1); endproperty
  a_qsel: assert property (p_qsel) else $error("bad q decode");
  property p_idle; !ccp && !main_pulse_zero |=> $stable(x); endproperty
  a_idle: assert property (p_idle) else $error("x moved idle");
  // One sequence at a time, so its resume must free the distributor
  sequence s_resume; sequence_done_pulse && !(|seq_start); endsequence
  property p_resume; s_resume |=> !mpd_halt; endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_step; seq_step == (seq_busy & {11{ccp}}); endproperty
  a_step: assert property (p_step) else $error("step without pulse");
  property p_qbits; q0 == q[0] && q1 == q[1] && q35 == q[35]; endproperty
  a_qbits: assert property (p_qbits) else $error("bad q stage out");
endmodule
bind xq_core xq_core_checker u_chk (.clock, .rst, .ccp, .main_pulse_zero,
  .clear_x, .complement_x, .load_x, .q_zero_to_x, .store_rd, .shift_q,
  .seq_start, .store_addr, .mpd_halt, .sequence_done_pulse, .q_selected,
  .x_top, .x_top_n, .q0, .q1, .q35, .seq_busy, .seq_step, .x, .q);
`default_nettype wire

/* File: testbench/xq_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Command timing model: one start pulse, counts halted cycles
module xq_ctl_model (
  // Clock and reset
  input wire logic clock, rst,
  // Bench side
  input wire logic go,
  input wire logic [3:0] idx,
  // Core side
  input wire logic mpd_halt,
  output logic [10:0] seq_start,
  output logic [4:0] hc
);
  // Distributor stands still while halted, so those cycles are counted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_start <= 11'h0;
      hc <= 5'h0;
    end else begin
      seq_start <= go ? 11'h1 << idx : 11'h0;
      if (go) hc <= 5'h0;
      else if (mpd_halt) hc <= hc + 5'h1;
    end
  end
endmodule
`default_nettype wire
